// ===== rtl/psb_pkg.sv
// Shared constants, types and helpers for the secondary bus ends
package psb_pkg;

  localparam int              AD_W        = 32;
  localparam int              BE_W        = 4;
  localparam int              WORD_W      = AD_W + BE_W;
  localparam int              LEN_W       = 8;
  localparam int              CMD_WR_BIT  = 0;
  localparam logic            ASSERTED    = 1'h0;
  localparam logic            DEASSERTED  = 1'h1;
  localparam logic [AD_W-1:0] AD_RST      = 32'h0000_0000;
  localparam logic [AD_W-1:0] AD_PULL     = 32'hFFFF_FFFF;
  localparam logic [BE_W-1:0] CBE_RST     = 4'hF;
  localparam logic [LEN_W-1:0] LEN_ONE    = 8'h01;
  localparam logic [1:0]      FIFO_EMPTY  = 2'h0;
  localparam logic [1:0]      FIFO_ONE    = 2'h1;
  localparam logic [1:0]      FIFO_FULL   = 2'h2;
  localparam logic [WORD_W-1:0] WORD_RST  = 36'h0_0000_0000;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_IADDR = 5'h02,
    S_IDATA = 5'h04,
    S_TDATA = 5'h08,
    S_REL   = 5'h10
  } psb_state_t;

  // Everything one end puts on the shared lines, with an enable per group
  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic            ad_oe;
    logic [BE_W-1:0] cbe_n;
    logic            cbe_oe;
    logic            par;
    logic            par_oe;
    logic            frame_n;
    logic            frame_oe;
    logic            irdy_n;
    logic            irdy_oe;
    logic            trdy_n;
    logic            trdy_oe;
  } psb_drv_t;

  localparam psb_drv_t DRV_RST = '{ad: AD_RST, ad_oe: 1'h0, cbe_n: CBE_RST, cbe_oe: 1'h0,
                                   par: 1'h0, par_oe: 1'h0, frame_n: DEASSERTED,
                                   frame_oe: 1'h0, irdy_n: DEASSERTED, irdy_oe: 1'h0,
                                   trdy_n: DEASSERTED, trdy_oe: 1'h0};

  function automatic logic psb_parity(input logic [AD_W-1:0] ad, input logic [BE_W-1:0] cbe);
    psb_parity = ^{ad, cbe};
  endfunction : psb_parity

  function automatic logic psb_is_write(input logic [BE_W-1:0] cmd);
    psb_is_write = cmd[CMD_WR_BIT];
  endfunction : psb_is_write

endpackage : psb_pkg

// ===== rtl/psb_bus_if.sv
// Secondary bus lines joining the bridge end and the agent end
`timescale 1ns/1ps
interface psb_bus_if;
  import psb_pkg::*;

  psb_drv_t        br_drv;
  psb_drv_t        ag_drv;
  logic [AD_W-1:0] ad;
  logic [BE_W-1:0] cbe_n;
  logic            par;
  logic            frame_n;
  logic            irdy_n;
  logic            trdy_n;

  // Undriven lines float to the pull-up level
  assign ad      = br_drv.ad_oe ? br_drv.ad : (ag_drv.ad_oe ? ag_drv.ad : AD_PULL);
  assign cbe_n   = br_drv.cbe_oe ? br_drv.cbe_n : (ag_drv.cbe_oe ? ag_drv.cbe_n : CBE_RST);
  assign par     = br_drv.par_oe ? br_drv.par : (ag_drv.par_oe ? ag_drv.par : DEASSERTED);
  assign frame_n = br_drv.frame_oe ? br_drv.frame_n
                 : (ag_drv.frame_oe ? ag_drv.frame_n : DEASSERTED);
  assign irdy_n  = br_drv.irdy_oe ? br_drv.irdy_n
                 : (ag_drv.irdy_oe ? ag_drv.irdy_n : DEASSERTED);
  assign trdy_n  = br_drv.trdy_oe ? br_drv.trdy_n
                 : (ag_drv.trdy_oe ? ag_drv.trdy_n : DEASSERTED);

  modport bridge (output br_drv, input ad, input cbe_n, input par,
                  input frame_n, input irdy_n, input trdy_n);
  modport agent  (output ag_drv, input ad, input cbe_n, input par,
                  input frame_n, input irdy_n, input trdy_n);

endinterface : psb_bus_if

// ===== rtl/psb_fifo2.sv
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
module psb_fifo2 (
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  input  wire logic                        in_valid_i,
  output logic                             in_ready_o,
  input  wire logic [psb_pkg::WORD_W-1:0]  in_data_i,
  output logic                             out_valid_o,
  output logic [psb_pkg::WORD_W-1:0]       out_data_o,
  input  wire logic                        out_ready_i
);
  import psb_pkg::*;

  logic [1:0]        cnt_ff;
  logic [WORD_W-1:0] mem_ff [0:1];
  logic              rdy_ff;
  logic              vld_ff;

  wire       push    = in_valid_i && rdy_ff;
  wire       pop     = vld_ff && out_ready_i;
  wire [1:0] nxt_cnt = cnt_ff + {1'h0, push} - {1'h0, pop};
  // Head always sits in entry 0 so the output is a plain register
  wire       ld_head = push && (cnt_ff == FIFO_EMPTY || (cnt_ff == FIFO_ONE && pop));
  wire       ld_tail = push && ((cnt_ff == FIFO_ONE && !pop) || (cnt_ff == FIFO_FULL && pop));

  assign in_ready_o  = rdy_ff;
  assign out_valid_o = vld_ff;
  assign out_data_o  = mem_ff[0];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= FIFO_EMPTY;
      rdy_ff <= 1'h1;
      vld_ff <= 1'h0;
    end else begin
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_cnt != FIFO_FULL;
      vld_ff <= nxt_cnt != FIFO_EMPTY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mem_ff[0] <= WORD_RST;
      mem_ff[1] <= WORD_RST;
    end else begin
      if (ld_head) begin
        mem_ff[0] <= in_data_i;
      end else if (pop) begin
        mem_ff[0] <= mem_ff[1];
      end
      if (ld_tail) begin
        mem_ff[1] <= in_data_i;
      end
    end
  end

endmodule : psb_fifo2

// ===== rtl/psb_bridge_end.sv
// Bridge side of the secondary parallel bus: initiator, target and bus parking
`timescale 1ns/1ps
module psb_bridge_end (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  psb_bus_if.bridge                       bus,
  input  wire logic                       park_i,
  input  wire logic                       req_valid_i,
  output logic                            req_ready_o,
  input  wire logic [psb_pkg::BE_W-1:0]   req_cmd_i,
  input  wire logic [psb_pkg::AD_W-1:0]   req_addr_i,
  input  wire logic [psb_pkg::LEN_W-1:0]  req_len_i,
  input  wire logic                       tx_valid_i,
  output logic                            tx_ready_o,
  input  wire logic [psb_pkg::AD_W-1:0]   tx_data_i,
  input  wire logic [psb_pkg::BE_W-1:0]   tx_be_n_i,
  output logic                            rx_valid_o,
  input  wire logic                       rx_ready_i,
  output logic [psb_pkg::AD_W-1:0]        rx_data_o,
  output logic [psb_pkg::BE_W-1:0]        rx_be_n_o,
  output logic                            tgt_start_o,
  output logic [psb_pkg::BE_W-1:0]        tgt_cmd_o,
  output logic [psb_pkg::AD_W-1:0]        tgt_addr_o
);
  import psb_pkg::*;

  psb_state_t        state_ff;
  psb_state_t        nxt_state;
  psb_drv_t          drv_ff;
  psb_drv_t          nxt_drv;
  logic              wr_ff;
  logic              nxt_wr;
  logic [LEN_W-1:0]  left_ff;
  logic [LEN_W-1:0]  nxt_left;
  logic              loaded_ff;
  logic              nxt_loaded;
  logic              frame_seen_ff;
  logic              req_ready_ff;
  logic              tgt_start_ff;
  logic [BE_W-1:0]   tgt_cmd_ff;
  logic [AD_W-1:0]   tgt_addr_ff;
  logic              txq_vld;
  logic [WORD_W-1:0] txq_word;
  logic              rxq_rdy;
  logic [WORD_W-1:0] rxq_word;

  wire xfer       = bus.irdy_n == ASSERTED && bus.trdy_n == ASSERTED;
  wire bus_idle   = bus.frame_n == DEASSERTED && bus.irdy_n == DEASSERTED;
  wire addr_phase = bus.frame_n == ASSERTED && frame_seen_ff == DEASSERTED;
  wire ini_phase  = state_ff == S_IADDR || state_ff == S_IDATA;
  wire ini_xfer   = state_ff == S_IDATA && xfer;
  wire tgt_xfer   = state_ff == S_TDATA && xfer;
  wire last_ini   = ini_xfer && left_ff == LEN_ONE;
  wire last_tgt   = tgt_xfer && bus.frame_n == DEASSERTED;
  wire [LEN_W-1:0] left_dec = ini_xfer ? left_ff - LEN_ONE : left_ff;
  wire start_ini  = req_valid_i && req_ready_ff && park_i && bus_idle;
  // Read data is taken one phase at a time; the receive slot never shrinks
  // while a ready line is low, so an asserted line never has to be withdrawn
  wire ini_offer  = wr_ff ? ((!loaded_ff || ini_xfer) && txq_vld) : (!loaded_ff && rxq_rdy);
  wire tgt_offer  = wr_ff ? (!loaded_ff && rxq_rdy) : ((!loaded_ff || tgt_xfer) && txq_vld);
  wire rx_push    = (ini_xfer && !wr_ff) || (tgt_xfer && wr_ff);
  wire tx_pop     = (ini_phase && wr_ff && ini_offer && !last_ini)
                  || (state_ff == S_TDATA && !wr_ff && tgt_offer && !last_tgt && !bus_idle);

  assign bus.br_drv  = drv_ff;
  assign req_ready_o = req_ready_ff;
  assign tgt_start_o = tgt_start_ff;
  assign tgt_cmd_o   = tgt_cmd_ff;
  assign tgt_addr_o  = tgt_addr_ff;
  assign rx_data_o   = rxq_word[AD_W-1:0];
  assign rx_be_n_o   = rxq_word[WORD_W-1:AD_W];

  psb_fifo2 u_txq (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_be_n_i, tx_data_i}),
    .out_valid_o (txq_vld),
    .out_data_o  (txq_word),
    .out_ready_i (tx_pop)
  );

  psb_fifo2 u_rxq (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rxq_rdy),
    .in_data_i   ({bus.cbe_n, bus.ad}),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rxq_word),
    .out_ready_i (rx_ready_i)
  );

  always_comb begin
    nxt_state     = state_ff;
    nxt_drv       = DRV_RST;
    nxt_drv.ad    = drv_ff.ad;
    nxt_drv.cbe_n = drv_ff.cbe_n;
    nxt_drv.par   = psb_parity(bus.ad, bus.cbe_n);
    nxt_wr        = wr_ff;
    nxt_left      = left_dec;
    nxt_loaded    = loaded_ff;
    unique case (state_ff)
      S_IDLE: begin
        nxt_drv.par_oe = drv_ff.ad_oe;
        if (addr_phase) begin
          nxt_state      = S_TDATA;
          nxt_wr         = psb_is_write(bus.cbe_n);
          nxt_loaded     = 1'h0;
          nxt_drv.par_oe = 1'h1;
        end else if (start_ini) begin
          nxt_state        = S_IADDR;
          nxt_drv.ad       = req_addr_i;
          nxt_drv.ad_oe    = 1'h1;
          nxt_drv.cbe_n    = req_cmd_i;
          nxt_drv.cbe_oe   = 1'h1;
          nxt_drv.frame_n  = ASSERTED;
          nxt_drv.frame_oe = 1'h1;
          nxt_drv.irdy_oe  = 1'h1;
          nxt_wr           = psb_is_write(req_cmd_i);
          nxt_left         = req_len_i;
          nxt_loaded       = 1'h0;
        end else if (park_i && bus_idle) begin
          // Parked: hold the last values so the lines never float
          nxt_drv.ad_oe  = 1'h1;
          nxt_drv.cbe_oe = 1'h1;
        end
      end
      S_IADDR, S_IDATA: begin
        nxt_state        = S_IDATA;
        nxt_drv.frame_oe = 1'h1;
        nxt_drv.irdy_oe  = 1'h1;
        nxt_drv.frame_n  = drv_ff.frame_n;
        nxt_drv.irdy_n   = drv_ff.irdy_n;
        nxt_drv.ad_oe    = wr_ff;
        nxt_drv.cbe_oe   = wr_ff;
        nxt_drv.par_oe   = state_ff == S_IADDR && !wr_ff;
        if (last_ini) begin
          nxt_state       = S_REL;
          nxt_drv.frame_n = DEASSERTED;
          nxt_drv.irdy_n  = DEASSERTED;
          nxt_drv.ad_oe   = 1'h0;
          nxt_drv.cbe_oe  = 1'h0;
        end else if (ini_offer) begin
          nxt_loaded      = 1'h1;
          nxt_drv.irdy_n  = ASSERTED;
          nxt_drv.frame_n = (left_dec == LEN_ONE) ? DEASSERTED : ASSERTED;
          if (wr_ff) begin
            {nxt_drv.cbe_n, nxt_drv.ad} = txq_word;
          end
        end else if (ini_xfer) begin
          nxt_loaded     = 1'h0;
          nxt_drv.irdy_n = DEASSERTED;
        end
      end
      S_TDATA: begin
        nxt_drv.trdy_oe = 1'h1;
        nxt_drv.trdy_n  = drv_ff.trdy_n;
        nxt_drv.ad_oe   = !wr_ff;
        nxt_drv.cbe_oe  = !wr_ff;
        nxt_drv.par_oe  = tgt_xfer && wr_ff;
        if (last_tgt || bus_idle) begin
          nxt_state      = S_REL;
          nxt_drv.trdy_n = DEASSERTED;
          nxt_drv.ad_oe  = 1'h0;
          nxt_drv.cbe_oe = 1'h0;
        end else if (tgt_offer) begin
          nxt_loaded     = 1'h1;
          nxt_drv.trdy_n = ASSERTED;
          if (!wr_ff) begin
            {nxt_drv.cbe_n, nxt_drv.ad} = txq_word;
          end
        end else if (tgt_xfer) begin
          nxt_loaded     = 1'h0;
          nxt_drv.trdy_n = DEASSERTED;
        end
      end
      S_REL: begin
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff  <= S_IDLE;
      drv_ff    <= DRV_RST;
      wr_ff     <= 1'h0;
      left_ff   <= LEN_ONE;
      loaded_ff <= 1'h0;
    end else begin
      state_ff  <= nxt_state;
      drv_ff    <= nxt_drv;
      wr_ff     <= nxt_wr;
      left_ff   <= nxt_left;
      loaded_ff <= nxt_loaded;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      frame_seen_ff <= DEASSERTED;
      req_ready_ff  <= 1'h0;
      tgt_start_ff  <= 1'h0;
      tgt_cmd_ff    <= CBE_RST;
      tgt_addr_ff   <= AD_RST;
    end else begin
      frame_seen_ff <= bus.frame_n;
      req_ready_ff  <= nxt_state == S_IDLE;
      tgt_start_ff  <= state_ff == S_IDLE && addr_phase;
      if (state_ff == S_IDLE && addr_phase) begin
        tgt_cmd_ff  <= bus.cbe_n;
        tgt_addr_ff <= bus.ad;
      end
    end
  end

endmodule : psb_bridge_end

// ===== rtl/psb_agent_end.sv
// Agent side of the secondary bus: one initiator or target on the far end
`timescale 1ns/1ps
module psb_agent_end (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  psb_bus_if.agent                        bus,
  input  wire logic                       gnt_i,
  input  wire logic                       req_valid_i,
  output logic                            req_ready_o,
  input  wire logic [psb_pkg::BE_W-1:0]   req_cmd_i,
  input  wire logic [psb_pkg::AD_W-1:0]   req_addr_i,
  input  wire logic [psb_pkg::LEN_W-1:0]  req_len_i,
  input  wire logic                       tx_valid_i,
  output logic                            tx_ready_o,
  input  wire logic [psb_pkg::AD_W-1:0]   tx_data_i,
  input  wire logic [psb_pkg::BE_W-1:0]   tx_be_n_i,
  output logic                            rx_valid_o,
  input  wire logic                       rx_ready_i,
  output logic [psb_pkg::WORD_W-1:0]      rx_word_o
);
  import psb_pkg::*;

  psb_state_t        state_ff;
  psb_state_t        nxt_state;
  psb_drv_t          drv_ff;
  psb_drv_t          nxt_drv;
  logic              wr_ff;
  logic              nxt_wr;
  logic [LEN_W-1:0]  left_ff;
  logic [LEN_W-1:0]  nxt_left;
  logic              loaded_ff;
  logic              nxt_loaded;
  logic              frame_seen_ff;
  logic              req_ready_ff;
  logic              txq_vld;
  logic [WORD_W-1:0] txq_word;
  logic              rxq_rdy;

  wire xfer       = bus.irdy_n == ASSERTED && bus.trdy_n == ASSERTED;
  wire bus_idle   = bus.frame_n == DEASSERTED && bus.irdy_n == DEASSERTED;
  wire addr_phase = bus.frame_n == ASSERTED && frame_seen_ff == DEASSERTED;
  wire ini_phase  = state_ff == S_IADDR || state_ff == S_IDATA;
  wire ini_xfer   = state_ff == S_IDATA && xfer;
  wire tgt_xfer   = state_ff == S_TDATA && xfer;
  wire last_ini   = ini_xfer && left_ff == LEN_ONE;
  wire last_tgt   = tgt_xfer && bus.frame_n == DEASSERTED;
  wire [LEN_W-1:0] left_dec = ini_xfer ? left_ff - LEN_ONE : left_ff;
  wire ini_offer  = wr_ff ? ((!loaded_ff || ini_xfer) && txq_vld) : (!loaded_ff && rxq_rdy);
  wire tgt_offer  = wr_ff ? (!loaded_ff && rxq_rdy) : ((!loaded_ff || tgt_xfer) && txq_vld);
  wire rx_push    = (ini_xfer && !wr_ff) || (tgt_xfer && wr_ff);
  wire tx_pop     = (ini_phase && wr_ff && ini_offer && !last_ini)
                  || (state_ff == S_TDATA && !wr_ff && tgt_offer && !last_tgt && !bus_idle);

  assign bus.ag_drv  = drv_ff;
  assign req_ready_o = req_ready_ff;

  psb_fifo2 u_txq (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_be_n_i, tx_data_i}),
    .out_valid_o (txq_vld),
    .out_data_o  (txq_word),
    .out_ready_i (tx_pop)
  );

  psb_fifo2 u_rxq (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rxq_rdy),
    .in_data_i   ({bus.cbe_n, bus.ad}),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_word_o),
    .out_ready_i (rx_ready_i)
  );

  // Parity is left to the bridge, so this end never drives PAR
  always_comb begin
    nxt_state     = state_ff;
    nxt_drv       = DRV_RST;
    nxt_drv.ad    = drv_ff.ad;
    nxt_drv.cbe_n = drv_ff.cbe_n;
    nxt_wr        = wr_ff;
    nxt_left      = left_dec;
    nxt_loaded    = loaded_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (addr_phase) begin
          nxt_state  = S_TDATA;
          nxt_wr     = psb_is_write(bus.cbe_n);
          nxt_loaded = 1'h0;
        end else if (req_valid_i && req_ready_ff && gnt_i && bus_idle) begin
          nxt_state        = S_IADDR;
          nxt_drv.ad       = req_addr_i;
          nxt_drv.ad_oe    = 1'h1;
          nxt_drv.cbe_n    = req_cmd_i;
          nxt_drv.cbe_oe   = 1'h1;
          nxt_drv.frame_n  = ASSERTED;
          nxt_drv.frame_oe = 1'h1;
          nxt_drv.irdy_oe  = 1'h1;
          nxt_wr           = psb_is_write(req_cmd_i);
          nxt_left         = req_len_i;
          nxt_loaded       = 1'h0;
        end
      end
      S_IADDR, S_IDATA: begin
        nxt_state        = S_IDATA;
        nxt_drv.frame_oe = 1'h1;
        nxt_drv.irdy_oe  = 1'h1;
        nxt_drv.frame_n  = drv_ff.frame_n;
        nxt_drv.irdy_n   = drv_ff.irdy_n;
        nxt_drv.ad_oe    = wr_ff;
        nxt_drv.cbe_oe   = wr_ff;
        if (last_ini) begin
          nxt_state       = S_REL;
          nxt_drv.frame_n = DEASSERTED;
          nxt_drv.irdy_n  = DEASSERTED;
          nxt_drv.ad_oe   = 1'h0;
          nxt_drv.cbe_oe  = 1'h0;
        end else if (ini_offer) begin
          nxt_loaded      = 1'h1;
          nxt_drv.irdy_n  = ASSERTED;
          nxt_drv.frame_n = (left_dec == LEN_ONE) ? DEASSERTED : ASSERTED;
          if (wr_ff) begin
            {nxt_drv.cbe_n, nxt_drv.ad} = txq_word;
          end
        end else if (ini_xfer) begin
          nxt_loaded     = 1'h0;
          nxt_drv.irdy_n = DEASSERTED;
        end
      end
      S_TDATA: begin
        nxt_drv.trdy_oe = 1'h1;
        nxt_drv.trdy_n  = drv_ff.trdy_n;
        nxt_drv.ad_oe   = !wr_ff;
        nxt_drv.cbe_oe  = !wr_ff;
        if (last_tgt || bus_idle) begin
          nxt_state      = S_REL;
          nxt_drv.trdy_n = DEASSERTED;
          nxt_drv.ad_oe  = 1'h0;
          nxt_drv.cbe_oe = 1'h0;
        end else if (tgt_offer) begin
          nxt_loaded     = 1'h1;
          nxt_drv.trdy_n = ASSERTED;
          if (!wr_ff) begin
            {nxt_drv.cbe_n, nxt_drv.ad} = txq_word;
          end
        end else if (tgt_xfer) begin
          nxt_loaded     = 1'h0;
          nxt_drv.trdy_n = DEASSERTED;
        end
      end
      S_REL: begin
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_ff      <= S_IDLE;
      drv_ff        <= DRV_RST;
      wr_ff         <= 1'h0;
      left_ff       <= LEN_ONE;
      loaded_ff     <= 1'h0;
      frame_seen_ff <= DEASSERTED;
      req_ready_ff  <= 1'h0;
    end else begin
      state_ff      <= nxt_state;
      drv_ff        <= nxt_drv;
      wr_ff         <= nxt_wr;
      left_ff       <= nxt_left;
      loaded_ff     <= nxt_loaded;
      frame_seen_ff <= bus.frame_n;
      req_ready_ff  <= nxt_state == S_IDLE;
    end
  end

endmodule : psb_agent_end

// ===== verif/psb_assertions.sv
// Concurrent checks on the lines between the bridge end and the agent end
`timescale 1ns/1ps
module psb_assertions (
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  input  wire psb_pkg::psb_drv_t        br_drv,
  input  wire psb_pkg::psb_drv_t        ag_drv,
  input  wire logic [psb_pkg::AD_W-1:0] ad,
  input  wire logic [psb_pkg::BE_W-1:0] cbe_n,
  input  wire logic                     par,
  input  wire logic                     frame_n,
  input  wire logic                     irdy_n,
  input  wire logic                     trdy_n
);
  import psb_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire xfer = !irdy_n && !trdy_n;
  sequence addr_ph(own, wr);
    $fell(frame_n) && own && (cbe_n[CMD_WR_BIT] == wr);
  endsequence
  par_even_a: assert property (
    br_drv.par_oe |-> par == ^{$past(ad), $past(cbe_n)}) else $error("odd parity");
  // A driven parity line must outlive the address lines by exactly one cycle
  par_release_a: assert property (
    $fell(br_drv.ad_oe) |-> (br_drv.par_oe || !$past(br_drv.par_oe)) ##1 !br_drv.par_oe)
    else $error("parity held after address lines released");
  frame_rel_a: assert property ($fell(br_drv.frame_oe) |-> $past(br_drv.frame_n))
    else $error("frame released without high cycle");
  irdy_rel_a: assert property ($fell(br_drv.irdy_oe) |-> $past(br_drv.irdy_n))
    else $error("irdy released without high cycle");
  trdy_rel_a: assert property ($fell(br_drv.trdy_oe) |-> $past(br_drv.trdy_n))
    else $error("trdy released without high cycle");
  irdy_hold_a: assert property (!irdy_n && trdy_n |=> !irdy_n)
    else $error("irdy dropped before transfer");
  trdy_hold_a: assert property (!trdy_n && irdy_n |=> !trdy_n)
    else $error("trdy dropped before transfer");
  last_phase_a: assert property (frame_n && !irdy_n |=> frame_n)
    else $error("frame asserted again in last phase");
  init_wr_par_a: assert property (
    addr_ph(br_drv.frame_oe, 1'h1) |=> !br_drv.par_oe [*3]) else $error("parity driven");
  tgt_rd_par_a: assert property (
    addr_ph(ag_drv.frame_oe, 1'b0) |=> br_drv.par_oe ##1 !br_drv.par_oe [*2])
    else $error("target read parity timing");
  tgt_wr_par_a: assert property (
    addr_ph(ag_drv.frame_oe, 1'b1) or (xfer && ag_drv.irdy_oe && ag_drv.ad_oe)
    |=> br_drv.par_oe) else $error("target write parity missing");
  be_owner_a: assert property (
    xfer |-> (br_drv.ad_oe ? br_drv.cbe_oe : (ag_drv.ad_oe && ag_drv.cbe_oe)))
    else $error("byte enables from wrong end");
endmodule : psb_assertions

// ===== verif/pci_secondary_bus_signaling_tb.sv
// Bridge end and agent end back to back, checked against queue models
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pci_secondary_bus_signaling_tb;
  import psb_pkg::*;
  logic                   clk_i = 1'b0;
  logic                   srst_i = 1'b1;
  logic                   park = 1'b0;
  logic                   gnt = 1'b0;
  logic [1:0]             req_v = 2'h0;
  logic [1:0]             tx_v = 2'h0;
  logic [1:0]             rx_r = 2'h0;
  logic [BE_W-1:0]        cmd = 4'h0;
  logic [AD_W-1:0]        addr = 32'h0000_0000;
  logic [LEN_W-1:0]       len = 8'h01;
  logic [1:0][WORD_W-1:0] tx_w = {2{WORD_RST}};
  logic [31:0]            seed = 32'h35a8_5aa4;
  logic [31:0]            dseed = 32'h35a8_5aa4;
  logic [WORD_W-1:0]      tgt_exp = WORD_RST;
  logic [WORD_W-1:0]      txq[2][$];
  logic [WORD_W-1:0]      rxq[2][$];
  wire  [1:0]             req_r, tx_r, rx_v;
  wire  [1:0][WORD_W-1:0] rx_w;
  wire                    tgt_start;
  wire  [BE_W-1:0]        tgt_cmd;
  wire  [AD_W-1:0]        tgt_addr;
  int                     failures = 0;
  int                     n_tests = 0;
  int                     n_start = 0;
  int                     n_far = 0;

  always #2 clk_i = ~clk_i;

  psb_bus_if bus ();
  psb_bridge_end i_psb_bridge_end (.clk_i(clk_i), .srst_i(srst_i), .bus(bus.bridge),
    .park_i(park), .req_valid_i(req_v[0]), .req_ready_o(req_r[0]), .req_cmd_i(cmd),
    .req_addr_i(addr), .req_len_i(len), .tx_valid_i(tx_v[0]), .tx_ready_o(tx_r[0]),
    .tx_data_i(tx_w[0][AD_W-1:0]), .tx_be_n_i(tx_w[0][WORD_W-1:AD_W]),
    .rx_valid_o(rx_v[0]), .rx_ready_i(rx_r[0]), .rx_data_o(rx_w[0][AD_W-1:0]),
    .rx_be_n_o(rx_w[0][WORD_W-1:AD_W]), .tgt_start_o(tgt_start), .tgt_cmd_o(tgt_cmd),
    .tgt_addr_o(tgt_addr));
  psb_agent_end i_psb_agent_end (.clk_i(clk_i), .srst_i(srst_i), .bus(bus.agent),
    .gnt_i(gnt), .req_valid_i(req_v[1]), .req_ready_o(req_r[1]), .req_cmd_i(cmd),
    .req_addr_i(addr), .req_len_i(len), .tx_valid_i(tx_v[1]), .tx_ready_o(tx_r[1]),
    .tx_data_i(tx_w[1][AD_W-1:0]), .tx_be_n_i(tx_w[1][WORD_W-1:AD_W]),
    .rx_valid_o(rx_v[1]), .rx_ready_i(rx_r[1]), .rx_word_o(rx_w[1]));
  psb_assertions i_psb_assertions (.clk_i(clk_i), .srst_i(srst_i), .br_drv(bus.br_drv),
    .ag_drv(bus.ag_drv), .ad(bus.ad), .cbe_n(bus.cbe_n), .par(bus.par),
    .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic conclude();
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // Feeds each end from its queue and checks every word popped on the far side
  always @(posedge clk_i) begin
    seed <= lfsr(seed);
    rx_r <= seed[2:1];
    // Counted so that a missing or stray address-phase pulse is caught
    n_start += int'(tgt_start === 1'h1);
    if (tgt_start) `CHK({tgt_cmd, tgt_addr}, tgt_exp)
    for (int i = 0; i < 2; i++) begin
      if (!srst_i && tx_v[i] && tx_r[i]) void'(txq[i].pop_front());
      tx_v[i] <= txq[i].size() > 0;
      tx_w[i] <= (txq[i].size() > 0) ? txq[i][0] : WORD_RST;
      if (!srst_i && rx_v[i] && rx_r[i]) begin
        `CHK(rx_w[i], (rxq[i].size() > 0) ? rxq[i][0] : 36'hx)
        if (rxq[i].size() > 0) void'(rxq[i].pop_front());
      end
    end
  end

  // One transaction; br = 1 when the bridge initiates
  task automatic run(input int br, input logic wr);
    int n, ini, src;
    dseed = lfsr(dseed);
    n = 1 + int'(dseed[1:0]);
    ini = 1 - br;
    n_far += ini;
    src = wr ? ini : br;
    park <= br[0];
    gnt <= !br[0];
    repeat (3) @(posedge clk_i);
    cmd <= {dseed[7:5], wr};
    addr <= dseed;
    len <= n[LEN_W-1:0];
    tgt_exp = {dseed[7:5], wr, dseed};
    for (int k = 0; k < n; k++) begin
      dseed = lfsr(dseed);
      txq[src].push_back({dseed[9:6], dseed});
      rxq[1-src].push_back({dseed[9:6], dseed});
    end
    req_v[ini] <= 1'b1;
    do @(posedge clk_i); while (!req_r[ini]);
    req_v[ini] <= 1'b0;
    @(posedge clk_i);
    for (int c = 0; c < 400 && (req_r != 2'h3 || rxq[0].size() + rxq[1].size() > 0); c++)
      @(posedge clk_i);
    `CHK(rxq[0].size() + rxq[1].size(), 0)
    `CHK(n_start, n_far)
    repeat (3) @(posedge clk_i);
    // Idle and parked: bridge must hold address, command and parity lines
    if (br == 1) `CHK({bus.br_drv.ad_oe, bus.br_drv.cbe_oe, bus.br_drv.par_oe}, 3'h7)
  endtask : run

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    for (int t = 0; t < 24; t++) run(t % 2, t[1]);
    conclude();
  end

  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule : pci_secondary_bus_signaling_tb
